//--- bench/gbr_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
module gbr_chk (
	// clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// routes and multiplexer
	input wire logic [7:0]  portb_radio_switch_route,
	input wire logic [11:0] portb_serial_txen_route,
	input wire logic [31:0] main_fsel_code,
	input wire logic [7:0]  main_fsel_valid,
	input wire logic [11:0] sec_fsel_code,
	input wire logic [2:0]  sec_fsel_valid,
	input wire logic [2:0]  sec_main_pin_function_select
);
	import gbr_pkg::*;
	// ==================================================
	// expected decode, rebuilt from the code ranges
	localparam logic [31:0] UNMAP = 32'h4001_7040;
	logic [7:0] mv;
	logic [2:0] sv;
	logic [2:0] sg;
	logic       wr_acc;
	assign wr_acc = psel && penable && pwrite;
	always_comb begin
		for (int i = 0; i < 8; i++) mv[i] = main_fsel_code[4*i+:4] <= MAIN_CODE_MAX;
		for (int i = 0; i < 3; i++) begin
			sv[i] = sec_fsel_code[4*i+:4] <= SEC_CODE_MAX;
			sg[i] = sv[i] && (sec_fsel_code[4*i+:4] >= SEC_GPIO_MIN);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==================================================
	// properties
	a_ready_high: assert property (pready)
		else $error("ready low");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	a_unmapped_err: assert property (psel && !penable && paddr == UNMAP
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr == A_PC_DIN
		|=> !pslverr)
		else $error("input data access refused");
	a_main_valid: assert property (main_fsel_valid == mv)
		else $error("main select decode");
	a_sec_valid: assert property (sec_fsel_valid == sv)
		else $error("secondary select decode");
	a_sec_gpio: assert property (sec_main_pin_function_select == sg)
		else $error("secondary plain pin decode");
	a_pb_radio: assert property (wr_acc && paddr == A_PB_RADIO
		|=> {24'h0, portb_radio_switch_route} == ($past(pwdata) & 32'h0000_00FF))
		else $error("second bank radio route");
	a_pb_txen: assert property (wr_acc && paddr == A_PB_TXEN
		|=> {20'h0, portb_serial_txen_route} == ($past(pwdata) & 32'h0000_0FFF))
		else $error("second bank txen route");
	c_unmapped: cover property (pslverr);
	c_radio: cover property (wr_acc && paddr == A_PB_RADIO);
	c_sec_gpio: cover property (sec_main_pin_function_select != 3'h0);
endmodule
bind gbr_bank gbr_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .portb_radio_switch_route(portb_radio_switch_route),
	.portb_serial_txen_route(portb_serial_txen_route), .main_fsel_code(main_fsel_code),
	.main_fsel_valid(main_fsel_valid), .sec_fsel_code(sec_fsel_code),
	.sec_fsel_valid(sec_fsel_valid), .sec_main_pin_function_select(sec_main_pin_function_select));
`default_nettype wire

//--- bench/gbr_pins.sv
`timescale 1ns/1ps
`default_nettype none
module gbr_pins (
	// design side
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	// outside world
	input wire logic [15:0] ext_lvl,
	input wire logic [12:0] fval,
	output logic     [15:0] pin_in,
	output logic     [12:0] func_value
);
	// a driven pin reads back its own level, an undriven one the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	assign func_value = fval;
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gbr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd, mcode;
	logic [15:0] pin_in, pin_out, pin_oe, ext_lvl;
	logic [12:0] fval, func_value;
	logic [7:0]  pb_radio, mvalid;
	logic [11:0] pb_txen, scode;
	logic [2:0]  svalid, sgpio;
	int          err_total, checks_done, cyc;
	gbr_bank #(.PINS(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .func_value(func_value), .portb_radio_switch_route(pb_radio),
		.portb_serial_txen_route(pb_txen), .main_fsel_code(mcode), .main_fsel_valid(mvalid),
		.sec_fsel_code(scode), .sec_fsel_valid(svalid), .sec_main_pin_function_select(sgpio));
	gbr_pins i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .fval(fval),
		.pin_in(pin_in), .func_value(func_value));
	always #10 pclk = ~pclk;
	// ==================================================
	// helpers
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask
	task automatic setx(input logic [15:0] v);
		@(posedge pclk);
		ext_lvl <= v;
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==================================================
	// scenarios
	logic [31:0] ra [7] = '{A_PC_PULSE, A_PC_CSEL, A_PC_RADIO, A_PC_TXEN, A_PC_FEN,
		A_PB_RADIO, A_PB_TXEN};
	logic [31:0] rm [7] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_0FFF,
		32'h0000_1FFF, 32'h0000_00FF, 32'h0000_0FFF};
	task automatic t_regs;
		foreach (ra[i]) rdchk(ra[i], 32'h0);
		foreach (ra[i]) begin
			apb(1'b1, ra[i], 32'hFFFF_FFFF);
			rdchk(ra[i], rm[i]);
		end
		chk({12'h0, pb_txen, pb_radio}, 32'h000F_FFFF);
		foreach (ra[i]) apb(1'b1, ra[i], 32'h0);
		$display("register table done");
	endtask
	task automatic t_pins;
		apb(1'b1, A_PC_DOUT, 32'h0000_A5A5);
		apb(1'b1, A_PC_DIRSET, 32'h0000_00FF);
		setx(16'h3C00);
		settle;
		chk({pin_oe, pin_out}, 32'h00FF_A5A5);
		apb(1'b1, A_PC_OCLR, 32'h0000_0005);
		settle;
		chk({16'h0, pin_out}, 32'h0000_A5A0);
		rdchk(A_PC_DOUT, 32'h0000_A5A0);
		rdchk(A_PC_OCLR, 32'h0);
		rdchk(A_PC_DIRSET, 32'h0000_00FF);
		rdchk(A_PC_DIN, 32'h0000_3CA0);
		apb(1'b1, A_PC_DIN, 32'h0000_FFFF);
		rdchk(A_PC_DIN, 32'h0000_3CA0);
		$display("pin data done");
	endtask
	task automatic t_alt;
		apb(1'b1, A_PC_FEN, 32'h0000_0001);
		apb(1'b1, A_PC_PULSE, 32'h0000_000E);
		apb(1'b1, A_PC_ALTSET, 32'h0000_4000);
		@(posedge pclk);
		fval <= 13'h0001;
		settle;
		chk({30'h0, pin_oe[14], pin_out[14]}, 32'h3);
		rdchk(A_PC_ALTSET, 32'h0000_4000);
		@(posedge pclk);
		fval <= 13'h0000;
		settle;
		chk({30'h0, pin_oe[14], pin_out[14]}, 32'h2);
		apb(1'b1, A_PC_ALTCLR, 32'h0000_4000);
		settle;
		chk({30'h0, pin_oe[14], pin_out[14]}, 32'h0);
		rdchk(A_PC_ALTSET, 32'h0);
		$display("alternate function done");
	endtask
	task automatic t_route;
		apb(1'b1, A_PC_FEN, 32'h0000_1238);
		apb(1'b1, A_PC_PULSE, 32'h0000_D000);
		apb(1'b1, A_PC_CSEL, 32'h0000_0098);
		apb(1'b1, A_PC_RADIO, 32'h0000_00A0);
		apb(1'b1, A_PC_TXEN, 32'h0000_0B00);
		apb(1'b1, A_PC_ALTSET, 32'h0000_2F00);
		@(posedge pclk);
		fval <= 13'h0218;
		settle;
		chk({20'h0, pin_oe[13:8], pin_out[13:8]}, 32'h0000_0BE5);
		@(posedge pclk);
		fval <= 13'h1020;
		settle;
		chk({31'h0, pin_out[13]}, 32'h0);
		chk({30'h0, pin_out[9], pin_out[8]}, 32'h2);
		chk({31'h0, pin_out[10]}, 32'h0);
		chk({31'h0, pin_out[11]}, 32'h1);
		@(posedge pclk);
		fval <= 13'h0000;
		apb(1'b1, A_PC_ALTCLR, 32'h0000_2F00);
		apb(1'b1, A_PC_FEN, 32'h0);
		settle;
		chk({20'h0, pin_oe[13:8], pin_out[13:8]}, 32'h0000_0025);
		$display("function routing done");
	endtask
	task automatic t_irq;
		setx(16'h0000);
		apb(1'b1, A_PC_KNDSET, 32'h0000_1000);
		apb(1'b1, A_PC_POLSET, 32'h0000_1000);
		apb(1'b1, A_PC_IENSET, 32'h0000_1000);
		settle;
		rdchk(A_PC_FLAGS, 32'h0);
		setx(16'h1800);
		settle;
		rdchk(A_PC_FLAGS, 32'h0000_1000);
		apb(1'b1, A_PC_IENCLR, 32'h0000_1000);
		settle;
		rdchk(A_PC_FLAGS, 32'h0);
		rdchk(A_PC_IENSET, 32'h0000_1000);
		apb(1'b1, A_PC_KNDCLR, 32'h0000_1000);
		settle;
		rdchk(A_PC_FLAGS, 32'h0000_1000);
		rdchk(A_PC_KNDSET, 32'h0);
		apb(1'b1, A_PC_POLCLR, 32'h0000_1000);
		apb(1'b1, A_PC_FLAGS, 32'h0000_1000);
		settle;
		rdchk(A_PC_FLAGS, 32'h0);
		rdchk(A_PC_POLSET, 32'h0);
		setx(16'h0800);
		settle;
		rdchk(A_PC_FLAGS, 32'h0000_1000);
		$display("pin events done");
	endtask
	task automatic t_mux;
		apb(1'b1, A_MAIN_FSEL, 32'hFB0A_5910);
		apb(1'b1, A_SEC_FSEL, 32'h0000_0654);
		settle;
		chk(mcode, 32'hFB0A_5910);
		chk({20'h0, scode}, 32'h0000_0654);
		chk({21'h0, sgpio, mvalid}, 32'h0000_033F);
		chk({29'h0, svalid}, 32'h0000_0003);
		apb(1'b1, 32'h4001_7040, 32'hFFFF_FFFF);
		rdchk(32'h4001_7040, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("multiplexer done");
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results;
		end
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		ext_lvl = 16'h0;
		fval = 13'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_pins;
		t_alt;
		t_route;
		t_irq;
		t_mux;
		results;
	end
endmodule
`default_nettype wire

//--- logic/gbr_bank.sv
// Operation
// - A one in a direction bit makes that third-bank pin an output, a zero keeps it an input unless a routed alternate function drives it.
// - Writing ones to the output-clear register clears those output data bits.
// - A one in an alternate-function bit lets the routed peripheral function drive that pin.
// - Writing ones to the alternate-function clear register drops those pins' selection.
// - Interrupt-set bits enable pin interrupts and interrupt-clear ones clear pin interrupts; interrupt-clear clears the flags and leaves the enables.
// - A kind bit of one senses edges, zero senses levels, and kind-clear returns to level.
// - A polarity bit of one is active high, zero active low, and its clear returns to low.
// - The function enable register holds thirteen enables in the documented bit order.
// - The pulse route register holds four pin selects, pulse three in the top nibble.
// - The chip-select route holds selects three to one up top and external interrupt lowest.
// - The radio route holds switch two in bits 7:4 and switch one in bits 3:0.
// - The transmit-enable route holds serial two, one and zero from high nibble down.
// - The second bank has the same radio and transmit-enable routes, reset to zero.
// - Main multiplexer fields select functions 0 to 10, other codes select nothing.
// - Secondary multiplexer fields select functions 0 to 5, the top codes plain pins.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gbr_bank #(
	parameter int PINS = 16
) (
	// clock and reset
	input  wire logic                                    pclk,
	input  wire logic                                    presetn,
	// register bus
	input  wire logic                                    psel,
	input  wire logic                                    penable,
	input  wire logic                                    pwrite,
	input  wire logic [31:0]                             paddr,
	input  wire logic [31:0]                             pwdata,
	output logic      [31:0]                             prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	// third bank pins
	input  wire logic [PINS-1:0]                         pin_in,
	output logic      [PINS-1:0]                         pin_out,
	output logic      [PINS-1:0]                         pin_oe,
	// peripheral function values, same order as the enable bits
	input  wire logic [gbr_pkg::FEN_W-1:0]               func_value,
	// second bank routes
	output logic      [gbr_pkg::RADIO_W-1:0]             portb_radio_switch_route,
	output logic      [gbr_pkg::TXEN_W-1:0]              portb_serial_txen_route,
	// pin multiplexer selects
	output logic      [gbr_pkg::MAIN_NF*gbr_pkg::NIB_W-1:0] main_fsel_code,
	output logic      [gbr_pkg::MAIN_NF-1:0]             main_fsel_valid,
	output logic      [gbr_pkg::SEC_NF*gbr_pkg::NIB_W-1:0]  sec_fsel_code,
	output logic      [gbr_pkg::SEC_NF-1:0]              sec_fsel_valid,
	output logic      [gbr_pkg::SEC_NF-1:0]              sec_main_pin_function_select
);
	import gbr_pkg::*;

	// ==================================================
	// elaboration check
	generate
		if (PINS < 1 || PINS > PIN_W) begin : g_bad_pins
			$error("gbr_bank: PINS must lie in 1..16");
		end
		// every multiplexer register packs its fields into one bus word
		if (MAIN_NF * NIB_W > 32 || SEC_NF * NIB_W > 32) begin : g_bad_fields
			$error("gbr_bank: multiplexer fields overflow a bus word");
		end
	endgenerate

	// ==================================================
	// decode helpers
	function automatic logic mapped(input logic [31:0] a);
		case (a)
			A_PB_RADIO, A_PB_TXEN, A_PC_DIN, A_PC_DOUT, A_PC_DIRSET,
			A_PC_OCLR, A_PC_ALTSET, A_PC_ALTCLR, A_PC_IENSET, A_PC_IENCLR,
			A_PC_KNDSET, A_PC_KNDCLR, A_PC_POLSET, A_PC_POLCLR, A_PC_FLAGS,
			A_PC_FEN, A_PC_PULSE, A_PC_CSEL, A_PC_RADIO, A_PC_TXEN,
			A_MAIN_FSEL, A_SEC_FSEL: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic code_ok(input logic [3:0] c, input logic [3:0] max);
		code_ok = (c <= max);
	endfunction

	// ==================================================
	// state
	logic [PINS-1:0]             din_q,   din_d;
	logic [PINS-1:0]             act_q,   act_d;
	logic [PINS-1:0]             dout_q,  dout_d;
	logic [PINS-1:0]             dir_q,   dir_d;
	logic [PINS-1:0]             alt_q,   alt_d;
	logic [PINS-1:0]             ien_q,   ien_d;
	logic [PINS-1:0]             kind_q,  kind_d;
	logic [PINS-1:0]             pol_q,   pol_d;
	logic [PINS-1:0]             flag_q,  flag_d;
	logic [FEN_W-1:0]            fen_q,   fen_d;
	logic [15:0]                 pulse_q, pulse_d;
	logic [15:0]                 csel_q,  csel_d;
	logic [RADIO_W-1:0]          radio_q, radio_d;
	logic [TXEN_W-1:0]           txen_q,  txen_d;
	logic [RADIO_W-1:0]          bradio_q, bradio_d;
	logic [TXEN_W-1:0]           btxen_q, btxen_d;
	logic [MAIN_NF*NIB_W-1:0]    mfs_q,   mfs_d;
	logic [SEC_NF*NIB_W-1:0]     sfs_q,   sfs_d;
	logic [31:0]                 rdat_q,  rdat_d;
	logic                        err_q,   err_d;
	logic [PINS-1:0]             pout_q,  pout_d;
	logic [PINS-1:0]             poe_q,   poe_d;
	logic [MAIN_NF-1:0]          mval_q,  mval_d;
	logic [SEC_NF-1:0]           sval_q,  sval_d;
	logic [SEC_NF-1:0]           sgpio_q, sgpio_d;

	logic                        setup;
	logic                        wr;
	logic [PINS-1:0]             wbits;
	logic [PINS-1:0]             act_now;
	logic [PINS-1:0]             event_now;
	logic [FEN_W*NIB_W-1:0]      fsel;
	logic [PINS-1:0]             r_hit;
	logic [PINS-1:0]             r_val;

	// ==================================================
	// bus handshake: never waits, so every access ends in two cycles
	assign pready  = 1'b1;
	assign setup   = psel & ~penable;
	// unmapped writes are dropped and only reported through pslverr
	assign wr      = psel & penable & pwrite & mapped(paddr);
	assign wbits   = pwdata[PINS-1:0];
	assign prdata  = rdat_q;
	assign pslverr = err_q & psel & penable;

	// ==================================================
	// function routing, enable bit f goes with select nibble f
	assign fsel[(FB_PULSE0+0)*NIB_W +: NIB_W] = pulse_q[3:0];
	assign fsel[(FB_PULSE0+1)*NIB_W +: NIB_W] = pulse_q[7:4];
	assign fsel[(FB_PULSE0+2)*NIB_W +: NIB_W] = pulse_q[11:8];
	assign fsel[(FB_PULSE0+3)*NIB_W +: NIB_W] = pulse_q[15:12];
	assign fsel[FB_EXTIRQ*NIB_W +: NIB_W]     = csel_q[3:0];
	assign fsel[(FB_CSEL1+0)*NIB_W +: NIB_W]  = csel_q[7:4];
	assign fsel[(FB_CSEL1+1)*NIB_W +: NIB_W]  = csel_q[11:8];
	assign fsel[(FB_CSEL1+2)*NIB_W +: NIB_W]  = csel_q[15:12];
	assign fsel[(FB_RADIO1+0)*NIB_W +: NIB_W] = radio_q[3:0];
	assign fsel[(FB_RADIO1+1)*NIB_W +: NIB_W] = radio_q[7:4];
	assign fsel[(FB_TXEN0+0)*NIB_W +: NIB_W]  = txen_q[3:0];
	assign fsel[(FB_TXEN0+1)*NIB_W +: NIB_W]  = txen_q[7:4];
	assign fsel[(FB_TXEN0+2)*NIB_W +: NIB_W]  = txen_q[11:8];

	gbr_route #(
		.PINS (PINS)
	) u_route (
		.fen  (fen_q),
		.fsel (fsel),
		.fval (func_value),
		.hit  (r_hit),
		.val  (r_val)
	);

	// ==================================================
	// interrupt detection
	// edge mode compares with last cycle's activity, so changing the polarity
	// of an edge pin can itself look like an edge and raise its flag
	always_comb begin
		act_now   = ~(din_q ^ pol_q);
		event_now = ien_q & (act_now & ~(kind_q & act_q));
	end

	// ==================================================
	// next state
	always_comb begin
		din_d    = pin_in;
		act_d    = act_now;
		dout_d   = dout_q;
		dir_d    = dir_q;
		alt_d    = alt_q;
		ien_d    = ien_q;
		kind_d   = kind_q;
		pol_d    = pol_q;
		flag_d   = flag_q;
		fen_d    = fen_q;
		pulse_d  = pulse_q;
		csel_d   = csel_q;
		radio_d  = radio_q;
		txen_d   = txen_q;
		bradio_d = bradio_q;
		btxen_d  = btxen_q;
		mfs_d    = mfs_q;
		sfs_d    = sfs_q;
		if (wr) begin
			case (paddr)
				A_PC_DOUT:   dout_d   = wbits;
				A_PC_DIRSET: dir_d    = wbits;
				A_PC_OCLR:   dout_d   = dout_q & ~wbits;
				A_PC_ALTSET: alt_d    = wbits;
				A_PC_ALTCLR: alt_d    = alt_q & ~wbits;
				A_PC_IENSET: ien_d    = wbits;
				A_PC_IENCLR: flag_d   = flag_q & ~wbits;
				A_PC_KNDSET: kind_d   = wbits;
				A_PC_KNDCLR: kind_d   = kind_q & ~wbits;
				A_PC_POLSET: pol_d    = wbits;
				A_PC_POLCLR: pol_d    = pol_q & ~wbits;
				A_PC_FLAGS:  flag_d   = flag_q & ~wbits;
				A_PC_FEN:    fen_d    = pwdata[FEN_W-1:0];
				A_PC_PULSE:  pulse_d  = pwdata[15:0];
				A_PC_CSEL:   csel_d   = pwdata[15:0];
				A_PC_RADIO:  radio_d  = pwdata[RADIO_W-1:0];
				A_PC_TXEN:   txen_d   = pwdata[TXEN_W-1:0];
				A_PB_RADIO:  bradio_d = pwdata[RADIO_W-1:0];
				A_PB_TXEN:   btxen_d  = pwdata[TXEN_W-1:0];
				A_MAIN_FSEL: mfs_d    = pwdata[MAIN_NF*NIB_W-1:0];
				A_SEC_FSEL:  sfs_d    = pwdata[SEC_NF*NIB_W-1:0];
				default:     ;
			endcase
		end
		// a new event beats a clear in the same cycle
		flag_d = flag_d | event_now;
	end

	// ==================================================
	// read data is caught in the setup cycle
	always_comb begin
		rdat_d = rdat_q;
		err_d  = err_q;
		if (setup) begin
			err_d = ~mapped(paddr);
			case (paddr)
				A_PC_DIN:    rdat_d = 32'(din_q);
				A_PC_DOUT:   rdat_d = 32'(dout_q);
				A_PC_DIRSET: rdat_d = 32'(dir_q);
				A_PC_ALTSET: rdat_d = 32'(alt_q);
				A_PC_IENSET: rdat_d = 32'(ien_q);
				A_PC_KNDSET: rdat_d = 32'(kind_q);
				A_PC_POLSET: rdat_d = 32'(pol_q);
				A_PC_FLAGS:  rdat_d = 32'(flag_q);
				A_PC_FEN:    rdat_d = 32'(fen_q);
				A_PC_PULSE:  rdat_d = 32'(pulse_q);
				A_PC_CSEL:   rdat_d = 32'(csel_q);
				A_PC_RADIO:  rdat_d = 32'(radio_q);
				A_PC_TXEN:   rdat_d = 32'(txen_q);
				A_PB_RADIO:  rdat_d = 32'(bradio_q);
				A_PB_TXEN:   rdat_d = 32'(btxen_q);
				A_MAIN_FSEL: rdat_d = 32'(mfs_q);
				A_SEC_FSEL:  rdat_d = 32'(sfs_q);
				// clear registers hold nothing, so they read back as zero
				A_PC_OCLR, A_PC_ALTCLR, A_PC_IENCLR,
				A_PC_KNDCLR, A_PC_POLCLR: rdat_d = RST_ZERO;
				// unmapped reads also return zero, with the error flag raised
				default:     rdat_d = RST_ZERO;
			endcase
		end
	end

	// ==================================================
	// pin drive, registered so the pads see clean levels
	always_comb begin
		pout_d = (alt_q & r_hit & r_val) | (~(alt_q & r_hit) & dout_q);
		poe_d  = dir_q | (alt_q & r_hit);
	end

	// ==================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_q    <= '0;
			act_q    <= '0;
			dout_q   <= '0;
			dir_q    <= '0;
			alt_q    <= '0;
			ien_q    <= '0;
			kind_q   <= '0;
			pol_q    <= '0;
			flag_q   <= '0;
			fen_q    <= '0;
			pulse_q  <= '0;
			csel_q   <= '0;
			radio_q  <= '0;
			txen_q   <= '0;
			bradio_q <= '0;
			btxen_q  <= '0;
			mfs_q    <= '0;
			sfs_q    <= '0;
			rdat_q   <= RST_ZERO;
			err_q    <= 1'b0;
			pout_q   <= '0;
			poe_q    <= '0;
			// code zero is a valid function and never a plain pin
			mval_q   <= '1;
			sval_q   <= '1;
			sgpio_q  <= '0;
		end else begin
			din_q    <= din_d;
			act_q    <= act_d;
			dout_q   <= dout_d;
			dir_q    <= dir_d;
			alt_q    <= alt_d;
			ien_q    <= ien_d;
			kind_q   <= kind_d;
			pol_q    <= pol_d;
			flag_q   <= flag_d;
			fen_q    <= fen_d;
			pulse_q  <= pulse_d;
			csel_q   <= csel_d;
			radio_q  <= radio_d;
			txen_q   <= txen_d;
			bradio_q <= bradio_d;
			btxen_q  <= btxen_d;
			mfs_q    <= mfs_d;
			sfs_q    <= sfs_d;
			rdat_q   <= rdat_d;
			err_q    <= err_d;
			pout_q   <= pout_d;
			poe_q    <= poe_d;
			mval_q   <= mval_d;
			sval_q   <= sval_d;
			sgpio_q  <= sgpio_d;
		end
	end

	// ==================================================
	// outputs
	assign pin_out                  = pout_q;
	assign pin_oe                   = poe_q;
	assign portb_radio_switch_route = bradio_q;
	assign portb_serial_txen_route  = btxen_q;
	assign main_fsel_code           = mfs_q;
	assign sec_fsel_code            = sfs_q;
	assign main_fsel_valid          = mval_q;
	assign sec_fsel_valid           = sval_q;
	assign sec_main_pin_function_select            = sgpio_q;

	// decode from the next code so the registered flags line up with the code
	genvar g;
	generate
		for (g = 0; g < MAIN_NF; g++) begin : g_main
			assign mval_d[g] = code_ok(mfs_d[g*NIB_W +: NIB_W],
				MAIN_CODE_MAX);
		end
		for (g = 0; g < SEC_NF; g++) begin : g_sec
			assign sval_d[g]  = code_ok(sfs_d[g*NIB_W +: NIB_W],
				SEC_CODE_MAX);
			assign sgpio_d[g] = code_ok(sfs_d[g*NIB_W +: NIB_W], SEC_CODE_MAX)
				& ~code_ok(sfs_d[g*NIB_W +: NIB_W], SEC_GPIO_MIN - 4'h1);
		end
	endgenerate
endmodule
`default_nettype wire

//--- logic/gbr_pkg.sv
`default_nettype none
package gbr_pkg;
	// ==================================================
	// widths and field layout
	localparam int PIN_W    = 16;
	localparam int NIB_W    = 4;
	localparam int FEN_W    = 13;
	localparam int MAIN_NF  = 8;
	localparam int SEC_NF   = 3;
	localparam int RADIO_W  = 8;
	localparam int TXEN_W   = 12;
	// function enable bit positions
	localparam int FB_PULSE0 = 0;
	localparam int FB_EXTIRQ = 4;
	localparam int FB_CSEL1  = 5;
	localparam int FB_RADIO1 = 8;
	localparam int FB_TXEN0  = 10;
	// ==================================================
	// pin multiplexer codes
	localparam logic [3:0] MAIN_CODE_MAX = 4'hA;
	localparam logic [3:0] SEC_CODE_MAX  = 4'h5;
	localparam logic [3:0] SEC_GPIO_MIN  = 4'h4;
	// ==================================================
	// register byte addresses
	localparam logic [31:0] A_PB_RADIO  = 32'h4001_1FC8;
	localparam logic [31:0] A_PB_TXEN   = 32'h4001_1FCC;
	localparam logic [31:0] A_PC_DIN    = 32'h4001_7000;
	localparam logic [31:0] A_PC_DOUT   = 32'h4001_7004;
	localparam logic [31:0] A_PC_DIRSET = 32'h4001_7010;
	localparam logic [31:0] A_PC_OCLR   = 32'h4001_7014;
	localparam logic [31:0] A_PC_ALTSET = 32'h4001_7018;
	localparam logic [31:0] A_PC_ALTCLR = 32'h4001_701C;
	localparam logic [31:0] A_PC_IENSET = 32'h4001_7020;
	localparam logic [31:0] A_PC_IENCLR = 32'h4001_7024;
	localparam logic [31:0] A_PC_KNDSET = 32'h4001_7028;
	localparam logic [31:0] A_PC_KNDCLR = 32'h4001_702C;
	localparam logic [31:0] A_PC_POLSET = 32'h4001_7030;
	localparam logic [31:0] A_PC_POLCLR = 32'h4001_7034;
	localparam logic [31:0] A_PC_FLAGS  = 32'h4001_7038;
	localparam logic [31:0] A_PC_FEN    = 32'h4001_703C;
	localparam logic [31:0] A_PC_PULSE  = 32'h4001_7FC0;
	localparam logic [31:0] A_PC_CSEL   = 32'h4001_7FC4;
	localparam logic [31:0] A_PC_RADIO  = 32'h4001_7FC8;
	localparam logic [31:0] A_PC_TXEN   = 32'h4001_7FCC;
	localparam logic [31:0] A_MAIN_FSEL = 32'h4001_7F00;
	localparam logic [31:0] A_SEC_FSEL  = 32'h4001_7F04;
	// ==================================================
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

//--- logic/gbr_route.sv
`timescale 1ns/1ps
`default_nettype none
module gbr_route #(
	parameter int PINS = 16
) (
	// function side
	input  wire logic [gbr_pkg::FEN_W-1:0]               fen,
	input  wire logic [gbr_pkg::FEN_W*gbr_pkg::NIB_W-1:0] fsel,
	input  wire logic [gbr_pkg::FEN_W-1:0]               fval,
	// pin side
	output logic      [PINS-1:0]                         hit,
	output logic      [PINS-1:0]                         val
);
	import gbr_pkg::*;

	// ==================================================
	// per pin: or of every enabled function aimed at it
	genvar p;
	generate
		for (p = 0; p < PINS; p++) begin : g_pin
			always_comb begin
				hit[p] = 1'b0;
				val[p] = 1'b0;
				for (int f = 0; f < FEN_W; f++) begin
					if (fen[f] && fsel[f*NIB_W +: NIB_W] == NIB_W'(p)) begin
						hit[p] = 1'b1;
						val[p] = val[p] | fval[f];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire
